/* wdt_sleep_params.svh */
// Constants of the watchdog and sleep/wake controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files; holds definitions only.
// Function
// - Config watchdog bit forces watchdog always running.
// - Otherwise soft enable bit switches watchdog.
// - Period code selects 1:32 doubling to 1:65536.
// - Period field resets to 1:512 code.
// - Soft enable bit resets to zero.
// - Control bits seven to five read zero.
// - Crystal wake holds watchdog cleared during startup.
// - Sleep clears watchdog and power-down flag, sets timeout flag, stops oscillator, holds pins.
// - Master clear resets; other wakes continue execution.
// - Power-down set at power-up; timeout cleared on watchdog wake.
// - Enabled interrupt wakes regardless of global enable.
// - After interrupt wake branch to vector if global enabled.
// - Sleep prefetches the next instruction address.
// - Interrupt or watchdog wake from sleep clears the watchdog.
// - Pending enabled interrupt makes sleep a no-op when global enable is clear.
// - Interrupt during sleep completes sleep, then wakes.
// - Watchdog reset never drives master clear pin.
// - Only clockless peripherals wake during sleep.
// - Watchdog time base is slow internal oscillator.
`ifndef WDT_SLEEP_PARAMS_SVH
`define WDT_SLEEP_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_WATCHDOG_CONTROL   16'h0018
`define IDX_OPTION_SETTINGS    16'h0081
`define IDX_CONFIGURATION_WORD 16'h2007
`define IDX_SLEEP_STATUS       16'h0003

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTL_SOFT_ON_BIT   0
`define CTL_PERIOD_LSB    1
`define CTL_PERIOD_MSB    4
`define CTL_RESET_PERIOD  4'h4
`define CTL_RESET_SOFT_ON 1'b0
`define OPT_ASSIGN_BIT    3
`define OPT_RATE_MSB      2
`define OPT_RESET         8'h00
`define CFG_WDT_ON_BIT    3
`define CFG_OSC_MSB       2
`define CFG_RESET         8'h00
`define STS_TIMEOUT_BIT   4
`define STS_POWERDOWN_BIT 3
`define STS_SLEEP_BIT     0
`define PERIOD_MAX_CODE   4'hB
`define PRESCALE_MIN      17'h00020
`define IRQ_VECTOR        13'h0004

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ            250000000
`define SLOW_OSC_HZ       31000
`define SLOW_DIV_CYCLES   (`CLK_HZ / `SLOW_OSC_HZ)
`define OST_TOSC          1024
`define OST_CYCLES        (`OST_TOSC * 1)

`endif

/* wdt_sleep_pkg.sv */
// Types shared by the watchdog and sleep/wake controller.
// Assumes the constants header is compiled alongside.
package wdt_sleep_pkg;

  typedef enum logic [1:0] {
    st_awake,
    st_sleep,
    st_ost
  } sleep_mode_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_state_t;

  typedef struct packed {
    sleep_mode_t mode;
    logic [3:0]  period;
    logic        soft_on;
    logic [7:0]  option;
    logic [7:0]  config_w;
    logic        timeout;
    logic        powerdown;
    logic [15:0] pre_cnt;
    logic [7:0]  post_cnt;
    logic [10:0] ost_cnt;
    logic [31:0] prdata;
    logic        wake;
    logic        branch;
    logic [12:0] resume_pc;
    logic        wdt_rst;
    logic        dev_rst;
  } wdt_state_t;

endpackage : wdt_sleep_pkg

/* slow_tick_gen.sv */
// Divider that turns the fast clock into the slow oscillator tick enable.
// Assumes one clock; the tick is a one-cycle pulse at the slow rate.
`timescale 1ns/1ps
`default_nettype none
module slow_tick_gen
  import wdt_sleep_pkg::*;
#(
  parameter int DIV = 8064
) (
  input  wire logic clk,
  input  wire logic rst_b,
  output var  logic tick
);

  tick_state_t st_ff;
  tick_state_t nxt_st;

  // ----------------------------------------------------------------
  // Free-running divider
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 16'(DIV - 1)) begin
      nxt_st.cnt  = 16'h0000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : slow_tick_gen
`default_nettype wire

/* watchdog_sleep_wake_control.sv */
// Watchdog timer with sleep entry and wake-up control, registers over APB.
// Assumes the core gives one-cycle sleep and clear pulses and level interrupt lines.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_sleep_params.svh"
module watchdog_sleep_wake_control
  import wdt_sleep_pkg::*;
#(
  parameter int         NUM_IRQ       = 12,
  parameter int         SLOW_DIV      = `SLOW_DIV_CYCLES,
  parameter logic [7:0] CRYSTAL_MODES = 8'h07
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [15:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire logic               sleep_instr,
  input  wire logic               watchdog_clear_instr,
  input  wire logic [12:0]        pc,
  input  wire logic               global_irq_enable,
  input  wire logic [NUM_IRQ-1:0] irq_enable,
  input  wire logic [NUM_IRQ-1:0] irq_flag,
  input  wire logic [NUM_IRQ-1:0] irq_clockless,
  input  wire logic               master_clear_req,
  output var  logic               core_halt,
  output var  logic               osc_driver_on,
  output var  logic               io_hold,
  output var  logic               wake_pulse,
  output var  logic               wake_to_vector,
  output var  logic [12:0]        vector_addr,
  output var  logic [12:0]        resume_pc,
  output var  logic               watchdog_reset_req,
  output var  logic               device_reset_req,
  output var  logic               master_clear_drive_b,
  output var  logic               timeout_flag,
  output var  logic               powerdown_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx[13:0], 2'b00};
  endfunction : byte_addr

  // Last prescaler count for a period code; reserved codes act as the longest
  function automatic logic [15:0] prescale_last(input logic [3:0] code);
    logic [3:0]  sat;
    logic [16:0] ratio;
    sat   = (code > `PERIOD_MAX_CODE) ? `PERIOD_MAX_CODE : code;
    ratio = `PRESCALE_MIN << sat;
    prescale_last = 16'(ratio - 17'h00001);
  endfunction : prescale_last

  function automatic logic [7:0] postscale_last(input logic [7:0] opt);
    logic [7:0] one_hot;
    one_hot = 8'h01 << opt[`OPT_RATE_MSB:0];
    postscale_last = opt[`OPT_ASSIGN_BIT] ? (one_hot - 8'h01) : 8'h00;
  endfunction : postscale_last

  // ----------------------------------------------------------------
  // Slow time base
  // ----------------------------------------------------------------
  logic slow_tick;

  slow_tick_gen #(
    .DIV (SLOW_DIV)
  ) i_slow_tick_gen (
    .clk   (clk),
    .rst_b (rst_b),
    .tick  (slow_tick)
  );

  wdt_state_t st_ff;
  wdt_state_t nxt_st;

  logic        wdt_on;
  logic        irq_pending;
  logic        irq_wake;
  logic        crystal;
  logic        expire;
  logic        setup_ph;
  logic        access_ph;
  logic        wr_en;
  logic        hit_ctl;
  logic        hit_opt;
  logic        hit_cfg;
  logic        hit_sts;
  logic        addr_hit;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Enables and events
  // ----------------------------------------------------------------
  always_comb begin
    wdt_on      = st_ff.config_w[`CFG_WDT_ON_BIT] | st_ff.soft_on;
    irq_pending = |(irq_enable & irq_flag);
    irq_wake    = |(irq_enable & irq_flag & irq_clockless);
    crystal     = CRYSTAL_MODES[st_ff.config_w[`CFG_OSC_MSB:0]];
    expire      = slow_tick & wdt_on & (st_ff.mode != st_ost)
                & (st_ff.pre_cnt == prescale_last(st_ff.period))
                & (st_ff.post_cnt == postscale_last(st_ff.option));
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  always_comb begin
    setup_ph  = psel & ~penable;
    access_ph = psel & penable;
    hit_ctl   = 1'b0;
    hit_opt   = 1'b0;
    hit_cfg   = 1'b0;
    hit_sts   = 1'b0;
    rd_word   = 32'h0000_0000;
    if (paddr == byte_addr(`IDX_WATCHDOG_CONTROL)) begin
      hit_ctl = 1'b1;
      rd_word = {27'h0000000, st_ff.period, st_ff.soft_on};
    end else if (paddr == byte_addr(`IDX_OPTION_SETTINGS)) begin
      hit_opt = 1'b1;
      rd_word = {24'h000000, st_ff.option};
    end else if (paddr == byte_addr(`IDX_CONFIGURATION_WORD)) begin
      hit_cfg = 1'b1;
      rd_word = {24'h000000, st_ff.config_w};
    end else if (paddr == byte_addr(`IDX_SLEEP_STATUS)) begin
      hit_sts = 1'b1;
      rd_word[`STS_TIMEOUT_BIT]   = st_ff.timeout;
      rd_word[`STS_POWERDOWN_BIT] = st_ff.powerdown;
      rd_word[`STS_SLEEP_BIT]     = (st_ff.mode != st_awake);
    end
    addr_hit = hit_ctl | hit_opt | hit_cfg | hit_sts;
    wr_en    = access_ph & pwrite & pstrb[0];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.wake    = 1'b0;
    nxt_st.wdt_rst = 1'b0;
    nxt_st.dev_rst = 1'b0;

    // Register reads are captured in the setup phase
    if (setup_ph) begin
      nxt_st.prdata = rd_word;
    end

    // Register writes
    if (wr_en && hit_ctl) begin
      nxt_st.period  = pwdata[`CTL_PERIOD_MSB:`CTL_PERIOD_LSB];
      nxt_st.soft_on = pwdata[`CTL_SOFT_ON_BIT];
    end
    if (wr_en && hit_opt) begin
      nxt_st.option = pwdata[7:0];
    end
    if (wr_en && hit_cfg) begin
      nxt_st.config_w = pwdata[7:0];
    end

    // Watchdog counting on the slow tick
    if (slow_tick && wdt_on && st_ff.mode != st_ost) begin
      if (st_ff.pre_cnt == prescale_last(st_ff.period)) begin
        nxt_st.pre_cnt = 16'h0000;
        if (st_ff.post_cnt == postscale_last(st_ff.option)) begin
          nxt_st.post_cnt = 8'h00;
        end else begin
          nxt_st.post_cnt = st_ff.post_cnt + 8'h01;
        end
      end else begin
        nxt_st.pre_cnt = st_ff.pre_cnt + 16'h0001;
      end
    end
    if (!wdt_on || watchdog_clear_instr) begin
      nxt_st.pre_cnt  = 16'h0000;
      nxt_st.post_cnt = 8'h00;
    end

    case (st_ff.mode)
      st_awake: begin
        if (master_clear_req) begin
          nxt_st.dev_rst = 1'b1;
        end else if (expire) begin
          nxt_st.wdt_rst = 1'b1;
          nxt_st.timeout = 1'b0;
        end else if (sleep_instr) begin
          if (irq_pending && !global_irq_enable) begin
            // Sleep acts as a no-op: counters and flags stay as they are
            nxt_st.pre_cnt  = st_ff.pre_cnt;
            nxt_st.post_cnt = st_ff.post_cnt;
          end else begin
            if (wdt_on) begin
              nxt_st.pre_cnt  = 16'h0000;
              nxt_st.post_cnt = 8'h00;
            end
            nxt_st.powerdown = 1'b0;
            nxt_st.timeout   = 1'b1;
            nxt_st.resume_pc = pc + 13'h0001;
            nxt_st.mode      = st_sleep;
          end
        end
      end
      st_sleep: begin
        if (master_clear_req) begin
          nxt_st.dev_rst = 1'b1;
          nxt_st.mode    = st_awake;
        end else if (irq_wake || expire) begin
          // An interrupt seen here arrived after sleep entry or was already pending with global enable set
          nxt_st.pre_cnt  = 16'h0000;
          nxt_st.post_cnt = 8'h00;
          nxt_st.branch   = global_irq_enable & ~expire;
          if (expire) begin
            nxt_st.timeout = 1'b0;
          end
          if (crystal) begin
            nxt_st.ost_cnt = 11'h000;
            nxt_st.mode    = st_ost;
          end else begin
            nxt_st.wake = 1'b1;
            nxt_st.mode = st_awake;
          end
        end
      end
      st_ost: begin
        nxt_st.pre_cnt  = 16'h0000;
        nxt_st.post_cnt = 8'h00;
        if (master_clear_req) begin
          nxt_st.dev_rst = 1'b1;
          nxt_st.mode    = st_awake;
        end else if (st_ff.ost_cnt == 11'(`OST_CYCLES - 1)) begin
          nxt_st.wake = 1'b1;
          nxt_st.mode = st_awake;
        end else begin
          nxt_st.ost_cnt = st_ff.ost_cnt + 11'h001;
        end
      end
      default: begin
        nxt_st.mode = st_awake;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff           <= '0;
      st_ff.mode      <= st_awake;
      st_ff.period    <= `CTL_RESET_PERIOD;
      st_ff.soft_on   <= `CTL_RESET_SOFT_ON;
      st_ff.option    <= `OPT_RESET;
      st_ff.config_w  <= `CFG_RESET;
      st_ff.timeout   <= 1'b1;
      st_ff.powerdown <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata               = st_ff.prdata;
  assign pready               = 1'b1;
  assign pslverr              = access_ph & ~addr_hit;
  assign core_halt            = (st_ff.mode != st_awake);
  assign osc_driver_on        = (st_ff.mode == st_awake);
  assign io_hold              = (st_ff.mode != st_awake);
  assign wake_pulse           = st_ff.wake;
  assign wake_to_vector       = st_ff.branch;
  assign vector_addr          = `IRQ_VECTOR;
  assign resume_pc            = st_ff.resume_pc;
  assign watchdog_reset_req   = st_ff.wdt_rst;
  assign device_reset_req     = st_ff.dev_rst;
  assign master_clear_drive_b = 1'b1;
  assign timeout_flag         = st_ff.timeout;
  assign powerdown_flag       = st_ff.powerdown;

endmodule : watchdog_sleep_wake_control
`default_nettype wire

/* wdt_sleep_sva.sv */
// Port-level checks of the watchdog and sleep/wake controller.
// Assumes a bind into the top module; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module wdt_sleep_sva
  import wdt_sleep_pkg::*;
#(
  parameter int NUM_IRQ = 12
) (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               sleep_instr,
  input wire logic [12:0]        pc,
  input wire logic               global_irq_enable,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic [NUM_IRQ-1:0] irq_flag,
  input wire logic [NUM_IRQ-1:0] irq_clockless,
  input wire logic               master_clear_req,
  input wire logic               core_halt,
  input wire logic               osc_driver_on,
  input wire logic               io_hold,
  input wire logic               wake_pulse,
  input wire logic               wake_to_vector,
  input wire logic [12:0]        vector_addr,
  input wire logic [12:0]        resume_pc,
  input wire logic               watchdog_reset_req,
  input wire logic               device_reset_req,
  input wire logic               master_clear_drive_b,
  input wire logic               timeout_flag,
  input wire logic               powerdown_flag
);
  // ------------------------------------------------------------
  // Sleep entry, wake and reset checks
  // ------------------------------------------------------------
  // ------------------------------------------------------------
  // Cycles spent asleep with a wake-capable interrupt pending
  // ------------------------------------------------------------
  logic        irq_wait;
  logic [10:0] wait_cnt_ff;
  assign irq_wait = core_halt && !master_clear_req
                    && (|(irq_enable & irq_flag & irq_clockless));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt_ff <= 11'h000;
    end else if (!irq_wait) begin
      wait_cnt_ff <= 11'h000;
    end else if (wait_cnt_ff != 11'h7FF) begin
      wait_cnt_ff <= wait_cnt_ff + 11'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_enter;
    !core_halt && sleep_instr && !master_clear_req
      && !((|(irq_enable & irq_flag)) && !global_irq_enable);
  endsequence
  sequence s_nop;
    !core_halt && sleep_instr && !master_clear_req
      && (|(irq_enable & irq_flag)) && !global_irq_enable;
  endsequence
  sequence s_wake;
    core_halt && !master_clear_req && (|(irq_enable & irq_flag & irq_clockless));
  endsequence
  sleep_entry_a:
    assert property (s_enter |=> watchdog_reset_req || (core_halt && !osc_driver_on
      && io_hold && timeout_flag && !powerdown_flag)) else $error("bad sleep entry");
  resume_addr_a:
    assert property (s_enter |=> watchdog_reset_req || resume_pc == $past(pc) + 13'h1)
      else $error("bad resume address");
  nop_sleep_a:
    assert property (s_nop |=> !core_halt && $stable(powerdown_flag))
      else $error("sleep not a no-op");
  irq_wake_a:
    assert property (s_wake |-> wait_cnt_ff < 11'h44C)
      else $error("no interrupt wake");
  wake_cont_a:
    assert property (wake_pulse |-> !core_halt && !device_reset_req && $past(core_halt))
      else $error("bad wake pulse");
  wake_vec_a:
    assert property (wake_pulse && timeout_flag |-> wake_to_vector == $past(global_irq_enable))
      else $error("bad vector choice");
  wdt_reset_a:
    assert property ($rose(watchdog_reset_req) |-> !timeout_flag && !core_halt)
      else $error("bad watchdog reset");
  master_clear_pin_reset_a:
    assert property ($rose(master_clear_req) |=> device_reset_req && !core_halt)
      else $error("no device reset");
  pin_vector_a:
    assert property (master_clear_drive_b && vector_addr == 13'h0004)
      else $error("pin driven or vector wrong");
endmodule : wdt_sleep_sva
bind watchdog_sleep_wake_control wdt_sleep_sva #(.NUM_IRQ(NUM_IRQ)) i_wdt_sleep_sva (.*);
`default_nettype wire

/* core_model.sv */
// Core-side model: sleep and watchdog-clear pulses, interrupt lines, master clear.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic        clk,
  output var  logic        sleep_instr,
  output var  logic        watchdog_clear_instr,
  output var  logic [12:0] pc,
  output var  logic        global_irq_enable,
  output var  logic [11:0] irq_enable,
  output var  logic [11:0] irq_flag,
  output var  logic [11:0] irq_clockless,
  output var  logic        master_clear_req
);
  initial begin
    sleep_instr = 1'b0;
    watchdog_clear_instr = 1'b0;
    pc = 13'h0000;
    global_irq_enable = 1'b0;
    irq_enable = 12'h000;
    irq_flag = 12'h000;
    irq_clockless = 12'h000;
    master_clear_req = 1'b0;
  end
  task automatic clear_wdt();
    watchdog_clear_instr <= 1'b1;
    @(posedge clk);
    watchdog_clear_instr <= 1'b0;
  endtask : clear_wdt
  task automatic do_sleep(input logic [12:0] at_pc);
    clear_wdt();
    @(posedge clk);
    sleep_instr <= 1'b1;
    pc          <= at_pc;
    @(posedge clk);
    sleep_instr <= 1'b0;
    @(posedge clk);
  endtask : do_sleep
  task automatic set_irq(input logic [11:0] en, fl, cl, input logic g);
    irq_enable        <= en;
    irq_flag          <= fl;
    irq_clockless     <= cl;
    global_irq_enable <= g;
  endtask : set_irq
  task automatic pulse_master_clear_pin();
    master_clear_req <= 1'b1;
    @(posedge clk);
    master_clear_req <= 1'b0;
  endtask : pulse_master_clear_pin
endmodule : core_model
`default_nettype wire

/* tb_watchdog_sleep_wake_control.sv */
// Self-checking bench for the watchdog and sleep/wake controller.
// Assumes the core model drives the core side; registers go over APB.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_sleep_params.svh"
module tb_watchdog_sleep_wake_control;
  import wdt_sleep_pkg::*;
  localparam int          DIV   = 4;
  localparam logic [15:0] A_CTL = 16'(`IDX_WATCHDOG_CONTROL * 4);
  localparam logic [15:0] A_OPT = 16'(`IDX_OPTION_SETTINGS * 4);
  localparam logic [15:0] A_CFG = 16'(`IDX_CONFIGURATION_WORD * 4);
  localparam logic [15:0] A_STS = 16'(`IDX_SLEEP_STATUS * 4);
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        sleep_instr, watchdog_clear_instr, global_irq_enable, master_clear_req;
  logic [12:0] pc, vector_addr, resume_pc;
  logic [11:0] irq_enable, irq_flag, irq_clockless;
  logic        core_halt, osc_driver_on, io_hold, wake_pulse, wake_to_vector;
  logic        watchdog_reset_req, device_reset_req, master_clear_drive_b;
  logic        timeout_flag, powerdown_flag;
  int          error_cnt = 0;
  int          checks    = 0;
  int          n;
  watchdog_sleep_wake_control #(.NUM_IRQ(12), .SLOW_DIV(DIV)) i_watchdog_sleep_wake_control (.*);
  core_model i_core_model (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Bus, compare and wait tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (k >= 20) begin
      error_cnt++;
      $display("[ERR] pready expected 1 seen 0");
      complete_run();
    end
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, q);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic wait_ev(input int s, input int lim, input logic must);
    logic [2:0] ev;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      ev = {device_reset_req, watchdog_reset_req, wake_pulse};
    end while (n < lim && ev[s] !== 1'b1);
    checks++;
    if (ev[s] !== must) begin
      error_cnt++;
      $display("[ERR] event %0d expected %b seen %b", s, must, ev[s]);
      if (must) complete_run();
    end
  endtask : wait_ev
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(A_CTL, 32'h08);
    rd(A_OPT, 32'h00);
    rd(A_CFG, 32'h00);
    rd(A_STS, 32'h18);
    wr(A_CTL, 32'hFF);
    rd(A_CTL, 32'h1F);
    apb(1'b0, 16'h0F00, 32'h0);
    chk("pslverr", 1, e);
    pstrb <= 4'h0;
    wr(A_CTL, 32'h00);
    pstrb <= 4'hF;
    rd(A_CTL, 32'h1F);
    $display("test registers done");
    wr(A_CTL, 32'h00);
    i_core_model.clear_wdt();
    wait_ev(1, 400, 1'b0);
    for (int c = 0; c < 3; c++) begin
      wr(A_CFG, (c > 0) ? 32'h0C : 32'h04);
      wr(A_CTL, 32'(c * 2 + (c == 0)));
      i_core_model.clear_wdt();
      wait_ev(1, 3000, 1'b1);
      chk("period", 1, n > (32 << c) * DIV - 4 && n < (32 << c) * DIV + 6);
      chk("timeout flag", 0, timeout_flag);
    end
    wr(A_CFG, 32'h04);
    wr(A_CTL, 32'h08);
    $display("test watchdog done");
    i_core_model.set_irq(12'h004, 12'h004, 12'h004, 1'b0);
    i_core_model.do_sleep(13'h0100);
    chk("nop halt", 0, core_halt);
    rd(A_STS, 32'h08);
    wr(A_CTL, 32'h09);
    for (int g = 1; g >= 0; g--) begin
      i_core_model.set_irq(12'h002, 12'h001, 12'hFFF, g[0]);
      i_core_model.do_sleep(13'h0123);
      chk("halt", 1, core_halt);
      chk("osc", 0, osc_driver_on);
      chk("io hold", 1, io_hold);
      chk("resume", 13'h0124, resume_pc);
      rd(A_STS, 32'h11);
      wait_ev(0, 40, 1'b0);
      i_core_model.set_irq(12'h004, 12'h004, 12'h000, g[0]);
      wait_ev(0, 40, 1'b0);
      i_core_model.set_irq(12'h004, 12'h004, 12'h004, g[0]);
      wait_ev(0, 40, 1'b1);
      chk("vector", g, wake_to_vector);
      i_core_model.set_irq(12'h000, 12'h000, 12'h000, g[0]);
    end
    wr(A_CTL, 32'h01);
    i_core_model.do_sleep(13'h0200);
    wait_ev(0, 400, 1'b1);
    chk("timeout flag", 0, timeout_flag);
    chk("vector", 0, wake_to_vector);
    wr(A_CTL, 32'h08);
    wr(A_CFG, 32'h00);
    i_core_model.do_sleep(13'h0300);
    i_core_model.set_irq(12'h001, 12'h001, 12'h001, 1'b0);
    wait_ev(0, 1200, 1'b1);
    chk("start-up", 1, n >= 1024 && n < 1034);
    i_core_model.set_irq(12'h000, 12'h000, 12'h000, 1'b0);
    i_core_model.do_sleep(13'h0400);
    i_core_model.pulse_master_clear_pin();
    wait_ev(2, 4, 1'b1);
    chk("halt", 0, core_halt);
    chk("powerdown flag", 0, powerdown_flag);
    $display("test sleep done");
    complete_run();
  end
endmodule : tb_watchdog_sleep_wake_control
`default_nettype wire
